// File: hdl/seglcd_device.sv
// Device end: serial decoder, display memory, settings
`timescale 1ns/1ps
module seglcd_device
   import seglcd_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   seglcd_link_if.dev      link,
   input  wire logic [4:0] i_disp_idx,
   output logic      [3:0] o_disp_nibble,
   output logic            o_osc_on,
   output logic            o_bias_on,
   output logic            o_timebase_en,
   output logic            o_wdt_flag_en,
   output logic            o_tone_on,
   output logic            o_tone_high,
   output clk_src_t        o_clk_src,
   output logic            o_bias_third,
   output logic      [1:0] o_commons,
   output logic            o_irq_en,
   output logic      [2:0] o_rate_sel,
   output logic            o_test_mode,
   output logic            o_timebase_clear,
   output logic            o_wdt_clear
);
   typedef enum logic [2:0] {ST_MODE, ST_ADDR, ST_DATA,
                             ST_CMD, ST_DROP} link_st_t;

   // Pin order: cs, wr, rd, data
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic       wr_prev_q;
   logic       rd_prev_q;
   logic       cs_idle;
   logic       din;
   logic       wr_rise;
   logic       wr_fall;
   logic       rd_fall;

   link_st_t   st_q;
   logic       is_rd_q;
   logic [3:0] cnt_q;
   logic [8:0] sh_q;
   logic [5:0] addr_q;
   logic [1:0] rd_idx_q;
   logic [2:0] nib_q;
   logic       mem_we_q;
   logic [4:0] mem_wa_q;
   logic [3:0] mem_wd_q;
   logic       cmd_fire_q;
   logic [7:0] code;
   logic [3:0] mem_q [32];
   logic       dout_q;
   logic       doe_q;

   always_ff @(posedge i_ref_clk) begin
      sync1_q <= {link.cs_n, link.wr_n, link.rd_n,
                  link.data_level};
      sync2_q <= sync1_q;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
      end else begin
         wr_prev_q <= sync2_q[2];
         rd_prev_q <= sync2_q[1];
      end
   end

   assign cs_idle = sync2_q[3];
   assign din     = sync2_q[0];
   assign wr_rise = sync2_q[2] && !wr_prev_q;
   assign wr_fall = !sync2_q[2] && wr_prev_q;
   assign rd_fall = !sync2_q[1] && rd_prev_q;

   // Frame sequencing; chip select high restarts at the id
   always_ff @(posedge i_ref_clk) begin
      mem_we_q   <= 1'b0;
      cmd_fire_q <= 1'b0;
      if (i_sys_rst || cs_idle) begin
         st_q     <= ST_MODE;
         is_rd_q  <= 1'b0;
         cnt_q    <= 4'h0;
         sh_q     <= 9'h0;
         addr_q   <= 6'h0;
         rd_idx_q <= 2'h0;
         nib_q    <= 3'h0;
         mem_wa_q <= 5'h0;
         mem_wd_q <= 4'h0;
      end else if (wr_rise) begin
         cnt_q <= cnt_q + 4'h1;
         unique case (st_q)
            ST_MODE: begin
               sh_q <= {sh_q[7:0], din};
               if (cnt_q == 4'h2) begin
                  cnt_q <= 4'h0;
                  if ({sh_q[1:0], din} == MODE_READ) begin
                     st_q    <= ST_ADDR;
                     is_rd_q <= 1'b1;
                  end else if ({sh_q[1:0], din} == MODE_WRITE) begin
                     st_q <= ST_ADDR;
                  end else if ({sh_q[1:0], din} == MODE_CMD) begin
                     st_q <= ST_CMD;
                  end else begin
                     st_q <= ST_DROP;
                  end
               end
            end
            ST_ADDR: begin
               addr_q <= {addr_q[4:0], din};
               if (cnt_q == 4'h5) begin
                  cnt_q    <= 4'h0;
                  rd_idx_q <= 2'h0;
                  st_q     <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (is_rd_q) begin
                  cnt_q <= cnt_q;
               end else if (cnt_q == 4'h3) begin
                  cnt_q    <= 4'h0;
                  mem_we_q <= 1'b1;
                  mem_wa_q <= addr_q[4:0];
                  mem_wd_q <= {din, nib_q};
                  addr_q   <= addr_q + 6'h1;
                  rd_idx_q <= 2'h0;
               end else begin
                  nib_q[cnt_q[1:0]] <= din;
               end
            end
            ST_CMD: begin
               sh_q <= {sh_q[7:0], din};
               if (cnt_q == 4'h8) begin
                  // Stay in command mode for chained codes
                  cnt_q      <= 4'h0;
                  cmd_fire_q <= 1'b1;
               end
            end
            ST_DROP: cnt_q <= cnt_q;
            default: st_q <= ST_DROP;
         endcase
      end else if (rd_fall && st_q == ST_DATA) begin
         // Under id 101 a read-back leaves the address alone
         rd_idx_q <= rd_idx_q + 2'h1;
         if (is_rd_q && rd_idx_q == 2'h3) begin
            addr_q <= addr_q + 6'h1;
         end
      end
   end

   // Only 32 nibbles exist; address bit 5 is ignored
   for (genvar i = 0; i < 32; i++) begin : g_mem
      always_ff @(posedge i_ref_clk) begin
         if (i_sys_rst) begin
            mem_q[i] <= 4'h0;
         end else if (mem_we_q && mem_wa_q == 5'(i)) begin
            mem_q[i] <= mem_wd_q;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      o_disp_nibble <= mem_q[i_disp_idx];
   end

   // Released on a write strobe so read-modify-write can drive
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || cs_idle || wr_fall) begin
         doe_q <= 1'b0;
      end else if (rd_fall && st_q == ST_DATA) begin
         doe_q <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         dout_q <= 1'b0;
      end else if (rd_fall && st_q == ST_DATA) begin
         dout_q <= mem_q[addr_q[4:0]][rd_idx_q];
      end
   end

   assign link.dev_data_out = dout_q;
   assign link.dev_data_oe  = doe_q;

   // Low bit of the 9-bit code is don't care
   assign code = sh_q[8:1];

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_osc_on      <= 1'b0;
         o_bias_on     <= 1'b0;
         o_timebase_en <= 1'b0;
         o_wdt_flag_en <= 1'b0;
         o_tone_on     <= 1'b0;
         o_tone_high   <= RST_TONE_HI;
         o_clk_src     <= SRC_RC;
         o_bias_third  <= 1'b0;
         o_commons     <= RST_COMMONS;
         o_irq_en      <= 1'b0;
         o_rate_sel    <= RST_RATE;
         o_test_mode   <= 1'b0;
      end else if (cmd_fire_q) begin
         casez (code)
            8'b0000_0000: begin
               o_osc_on  <= 1'b0;
               o_bias_on <= 1'b0;
            end
            8'b0000_0001: o_osc_on <= 1'b1;
            8'b0000_0010: o_bias_on <= 1'b0;
            8'b0000_0011: o_bias_on <= 1'b1;
            8'b0000_0100: o_timebase_en <= 1'b0;
            8'b0000_0110: o_timebase_en <= 1'b1;
            8'b0000_0101: o_wdt_flag_en <= 1'b0;
            8'b0000_0111: o_wdt_flag_en <= 1'b1;
            8'b0000_1000: o_tone_on <= 1'b0;
            8'b0000_1001: o_tone_on <= 1'b1;
            // Rates downstream follow this source
            8'b0001_01??: o_clk_src <= SRC_XTAL;
            8'b0001_10??: o_clk_src <= SRC_RC;
            8'b0001_11??: o_clk_src <= SRC_EXT;
            8'b0010_????: begin
               // Commons code 11 is undefined; whole code ignored
               if (code[3:2] != 2'b11) begin
                  o_commons    <= code[3:2];
                  o_bias_third <= code[0];
               end
            end
            8'b010?_????: o_tone_high <= 1'b1;
            8'b011?_????: o_tone_high <= 1'b0;
            8'b100?_????: o_irq_en <= code[3];
            8'b101?_????: o_rate_sel <= code[2:0];
            8'b1110_0000: o_test_mode <= 1'b1;
            8'b1110_0011: o_test_mode <= 1'b0;
            default: o_test_mode <= o_test_mode;
         endcase
      end
   end

   // Clear pulses for the counters, one cycle each
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_timebase_clear <= 1'b0;
         o_wdt_clear      <= 1'b0;
      end else begin
         o_timebase_clear <= cmd_fire_q &&
                             code[7:2] == 6'b0000_11;
         o_wdt_clear      <= cmd_fire_q &&
                             code[7:1] == 7'b0000_111;
      end
   end
endmodule

// File: hdl/seglcd_pkg.sv
// Shared constants for the segment display serial link
// Overview of operation
// - Read: id 110, address, nibble returned
// - Write: id 101, address, nibble stored
// - Id 101 also allows read-back then rewrite
// - Address bit5 first, data bit0 first
// - Code 00 stops oscillator and bias; 01 starts the oscillator only
// - Code 02 bias off, 03 bias on
// - Code 04 time base off, 06 on
// - Code 05 watchdog flag off, 07 on
// - Code 08 tone off, 09 on
// - Codes 0000-11XX clear time base count
// - Codes 0000-111X clear watchdog count
// - Codes 0001-01/10/11 select clock source
// - Code 0010-abXc sets bias and commons
// - Codes 010X/011X pick 4 or 2 kHz
// - Code 101X-Xnnn picks 1 to 128 Hz
// - Reset defaults; 100X-1/0 flag pin on/off
// - Commands chain without repeating id 100
// - Rates derive from selected clock source
// - Host sends initialisation after power-up
// - Bits sampled on write strobe rising edge
// - Read bits driven on read strobe fall
// - Chip select high aborts; new id next
package seglcd_pkg;
   localparam logic [2:0] MODE_READ  = 3'h6;
   localparam logic [2:0] MODE_WRITE = 3'h5;
   localparam logic [2:0] MODE_CMD   = 3'h4;

   typedef enum logic [1:0] {SRC_XTAL, SRC_RC, SRC_EXT} clk_src_t;

   // Power-on defaults of the device
   localparam logic [2:0] RST_RATE    = 3'h7;
   localparam logic [1:0] RST_COMMONS = 2'h2;
   localparam logic       RST_TONE_HI = 1'b0;

   // Host register offsets and fields
   localparam logic [3:0] REG_CMD    = 4'h0;
   localparam logic [3:0] REG_WRITE  = 4'h4;
   localparam logic [3:0] REG_READ   = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CMD_KEEP_BIT = 9;
   localparam int WR_DATA_LSB  = 6;
   localparam int ST_BUSY_BIT  = 4;
   localparam int ST_OPEN_BIT  = 5;

   // Strobe half period; must exceed both synchroniser delays
   localparam int CLK_PERIOD_NS = 25;
   localparam int LINK_HALF_NS  = 200;
   localparam logic [3:0] LINK_HALF_CYC =
      4'((LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// File: hdl/seglcd_link_if.sv
// Three-wire serial link between host and display driver
`timescale 1ns/1ps
interface seglcd_link_if;
   logic cs_n;
   logic wr_n;
   logic rd_n;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic data_level;

   // Pulled high when nobody drives
   assign data_level = host_data_oe ? host_data_out :
                       (dev_data_oe ? dev_data_out : 1'b1);

   modport host (output cs_n, output wr_n, output rd_n,
                 output host_data_out, output host_data_oe,
                 input data_level);
   modport dev  (input cs_n, input wr_n, input rd_n,
                 output dev_data_out, output dev_data_oe,
                 input data_level);
endinterface

// File: hdl/seglcd_host.sv
// Host end: register port to serial frames
`timescale 1ns/1ps
module seglcd_host
   import seglcd_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   seglcd_link_if.host      link
);
   typedef enum logic [2:0] {H_IDLE, H_CSUP, H_WLO, H_WHI,
                             H_RLO, H_RHI, H_END} host_st_t;

   host_st_t    st_q;
   logic [3:0]  tm_q;
   logic [12:0] tx_q;
   logic [3:0]  left_q;
   logic [1:0]  ridx_q;
   logic        is_rd_q;
   logic        keep_q;
   logic        open_q;
   logic [3:0]  rnib_q;
   logic [1:0]  din_s_q;
   logic        cs_n_q;
   logic        wr_n_q;
   logic        rd_n_q;
   logic        dout_q;
   logic        doe_q;
   logic        half_end;
   logic        start;

   assign half_end = (tm_q == LINK_HALF_CYC - 4'h1);
   // Orders arriving while busy are dropped
   assign start = i_wr && (st_q == H_IDLE) &&
                  (i_addr inside {REG_CMD, REG_WRITE, REG_READ});

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || st_q == H_IDLE || half_end) begin
         tm_q <= 4'h0;
      end else begin
         tm_q <= tm_q + 4'h1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      din_s_q <= {din_s_q[0], link.data_level};
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_q    <= H_IDLE;
         tx_q    <= 13'h0;
         left_q  <= 4'h0;
         ridx_q  <= 2'h0;
         is_rd_q <= 1'b0;
         keep_q  <= 1'b0;
         open_q  <= 1'b0;
         rnib_q  <= 4'h0;
      end else if (start) begin
         is_rd_q <= (i_addr == REG_READ);
         keep_q  <= (i_addr == REG_CMD) && i_wdata[CMD_KEEP_BIT];
         st_q    <= H_CSUP;
         ridx_q  <= 2'h0;
         unique case (i_addr)
            REG_CMD: begin
               if (open_q) begin
                  tx_q   <= {i_wdata[8:0], 4'h0};
                  left_q <= 4'd9;
                  st_q   <= H_WLO;
               end else begin
                  tx_q   <= {MODE_CMD, i_wdata[8:0], 1'b0};
                  left_q <= 4'd12;
               end
            end
            REG_WRITE: begin
               tx_q   <= {MODE_WRITE, i_wdata[5:0],
                          i_wdata[WR_DATA_LSB],
                          i_wdata[WR_DATA_LSB+1],
                          i_wdata[WR_DATA_LSB+2],
                          i_wdata[WR_DATA_LSB+3]};
               left_q <= 4'd13;
            end
            default: begin
               tx_q   <= {MODE_READ, i_wdata[5:0], 4'h0};
               left_q <= 4'd9;
            end
         endcase
      end else if (half_end) begin
         unique case (st_q)
            H_CSUP: st_q <= H_WLO;
            H_WLO:  st_q <= H_WHI;
            H_WHI: begin
               tx_q   <= {tx_q[11:0], 1'b0};
               left_q <= left_q - 4'h1;
               if (left_q != 4'h1) begin
                  st_q <= H_WLO;
               end else if (is_rd_q) begin
                  st_q <= H_RLO;
               end else if (keep_q) begin
                  st_q   <= H_IDLE;
                  open_q <= 1'b1;
               end else begin
                  st_q <= H_END;
               end
            end
            H_RLO:  st_q <= H_RHI;
            H_RHI: begin
               rnib_q[ridx_q] <= din_s_q[1];
               ridx_q         <= ridx_q + 2'h1;
               st_q           <= (ridx_q == 2'h3) ? H_END : H_RLO;
            end
            H_END: begin
               st_q   <= H_IDLE;
               open_q <= 1'b0;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cs_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         dout_q <= 1'b0;
         doe_q  <= 1'b0;
      end else begin
         cs_n_q <= (st_q == H_CSUP) || (st_q == H_END) ||
                   (st_q == H_IDLE && !open_q);
         wr_n_q <= (st_q != H_WLO);
         rd_n_q <= (st_q != H_RLO);
         dout_q <= tx_q[12];
         doe_q  <= (st_q == H_WLO) || (st_q == H_WHI);
      end
   end

   assign link.cs_n          = cs_n_q;
   assign link.wr_n          = wr_n_q;
   assign link.rd_n          = rd_n_q;
   assign link.host_data_out = dout_q;
   assign link.host_data_oe  = doe_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !i_rd || i_addr != REG_STATUS) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= {26'h0, open_q, (st_q != H_IDLE), rnib_q};
      end
   end
endmodule

// File: verification/seglcd_link_props.sv
// Timing and ownership checks on the three-wire display link
`timescale 1ns/1ps
module seglcd_link_props (
   input  wire logic i_ref_clk,
   input  wire logic i_sys_rst,
   input  wire logic cs_n,
   input  wire logic wr_n,
   input  wire logic rd_n,
   input  wire logic host_data_out,
   input  wire logic host_data_oe,
   input  wire logic dev_data_out,
   input  wire logic dev_data_oe,
   input  wire logic data_level
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   strobe_in_cs_a: assert property ((!wr_n || !rd_n) |-> !cs_n)
      else $error("Strobe active while chip select high");
   one_strobe_a: assert property (!(!wr_n && !rd_n))
      else $error("Both strobes low together");
   wr_low_len_a: assert property ($fell(wr_n) |-> !wr_n [*4])
      else $error("Write strobe low phase too short");
   rd_low_len_a: assert property ($fell(rd_n) |-> !rd_n [*4])
      else $error("Read strobe low phase too short");
   cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*2])
      else $error("Chip select high pulse too short");
   wr_data_hold_a: assert property ((!wr_n && !$past(wr_n)) |-> ($stable(host_data_out) && host_data_oe))
      else $error("Host data not held while write strobe low");
   no_clash_a: assert property (dev_data_oe |-> !host_data_oe)
      else $error("Host and device drive the data line together");
   dev_drive_start_a: assert property ($rose(dev_data_oe) |-> (!rd_n && !cs_n))
      else $error("Device drive began outside a read strobe low phase");
   dev_bit_hold_a: assert property ((rd_n && $past(rd_n) && dev_data_oe && $past(dev_data_oe)) |->
      ($stable(dev_data_out) && $stable(data_level)))
      else $error("Device bit changed while read strobe high");
   dev_release_a: assert property (cs_n [*6] |-> !dev_data_oe)
      else $error("Device still drives data after chip select high");
endmodule

// File: verification/segment_lcd_command_decoder_bench.sv
// Bench: host and device joined over the link, driven via host registers
`timescale 1ns/1ps
module segment_lcd_command_decoder_bench;
   import seglcd_pkg::*;
   logic        i_ref_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [4:0]  i_disp_idx = 5'h0;
   logic [31:0] o_rdata;
   logic [3:0]  o_disp_nibble;
   logic        o_osc_on, o_bias_on, o_timebase_en, o_wdt_flag_en, o_tone_on, o_tone_high;
   logic        o_bias_third, o_irq_en, o_test_mode, o_timebase_clear, o_wdt_clear;
   clk_src_t    o_clk_src;
   logic [1:0]  o_commons;
   logic [2:0]  o_rate_sel;
   logic [1:0]  tb_clr_cnt = 2'h0;
   logic [1:0]  wdt_clr_cnt = 2'h0;
   logic [15:0] wire_bits = 16'h0;
   logic [3:0]  rd_bits = 4'h0;
   logic        wr_q = 1'b1, rd_q = 1'b1, cs_q = 1'b1, dl_q = 1'b1;
   logic [31:0] rv;
   int          miscompares = 0;
   int          n_compared = 0;
   int          i;
   // Code in the top byte, expected settings below
   logic [27:0] steps [32] = '{28'h0108127, 28'h030c127, 28'h0208127, 28'h030c127, 28'h0000127, 28'h0108127,
      28'h060a127, 28'h070b127, 28'h0409127, 28'h0508127, 28'h0908927, 28'h0808127, 28'h0c48127, 28'h0e98127,
      28'h1498027, 28'h1f98227, 28'h1998127, 28'h1198127, 28'h2198187, 28'h2498117, 28'h2d98117, 28'h2b981a7,
      28'h5f985a7, 28'h60981a7, 28'h88981e7, 28'h97981a7, 28'ha0981a0, 28'hb3981a3, 28'ha7981a7, 28'he0981af,
      28'he3981a7, 28'hc0981a7};

   seglcd_link_if seglcd_link_if_i ();
   seglcd_host seglcd_host_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(seglcd_link_if_i));
   seglcd_device seglcd_device_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(seglcd_link_if_i),
      .i_disp_idx(i_disp_idx), .o_disp_nibble(o_disp_nibble), .o_osc_on(o_osc_on), .o_bias_on(o_bias_on),
      .o_timebase_en(o_timebase_en), .o_wdt_flag_en(o_wdt_flag_en), .o_tone_on(o_tone_on),
      .o_tone_high(o_tone_high), .o_clk_src(o_clk_src), .o_bias_third(o_bias_third), .o_commons(o_commons),
      .o_irq_en(o_irq_en), .o_rate_sel(o_rate_sel), .o_test_mode(o_test_mode),
      .o_timebase_clear(o_timebase_clear), .o_wdt_clear(o_wdt_clear));
   seglcd_link_props seglcd_link_props_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .cs_n(seglcd_link_if_i.cs_n), .wr_n(seglcd_link_if_i.wr_n), .rd_n(seglcd_link_if_i.rd_n),
      .host_data_out(seglcd_link_if_i.host_data_out), .host_data_oe(seglcd_link_if_i.host_data_oe),
      .dev_data_out(seglcd_link_if_i.dev_data_out), .dev_data_oe(seglcd_link_if_i.dev_data_oe),
      .data_level(seglcd_link_if_i.data_level));

   always #12.5 i_ref_clk = ~i_ref_clk;

   // Wire monitor; write bits taken from the last low cycle in case the host releases at the rise
   always @(posedge i_ref_clk) begin
      wr_q <= seglcd_link_if_i.wr_n;
      rd_q <= seglcd_link_if_i.rd_n;
      cs_q <= seglcd_link_if_i.cs_n;
      dl_q <= seglcd_link_if_i.data_level;
      if (cs_q && !seglcd_link_if_i.cs_n) wire_bits <= 16'h0;
      else if (seglcd_link_if_i.wr_n && !wr_q) wire_bits <= {wire_bits[14:0], dl_q};
      if (seglcd_link_if_i.rd_n && !rd_q) rd_bits <= {rd_bits[2:0], seglcd_link_if_i.data_level};
      if (o_timebase_clear) tb_clr_cnt <= tb_clr_cnt + 2'h1;
      if (o_wdt_clear) wdt_clr_cnt <= wdt_clr_cnt + 2'h1;
   end

   function automatic logic [19:0] dev_state();
      return {tb_clr_cnt, wdt_clr_cnt, o_osc_on, o_bias_on, o_timebase_en, o_wdt_flag_en, o_tone_on,
              o_tone_high, o_clk_src, o_bias_third, o_irq_en, o_commons, o_test_mode, o_rate_sel};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic sys_reset();
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      d = o_rdata;
   endtask

   // Bounded poll of the busy flag; leaves the idle status in rv
   task automatic wait_idle();
      int k;
      k = 0;
      rv = 32'h10;
      while (rv[ST_BUSY_BIT] !== 1'b0 && k < 400) begin
         reg_rd(REG_STATUS, rv);
         k++;
      end
      if (k == 400) miscompares++;
      repeat (4) @(posedge i_ref_clk);
   endtask

   task automatic cmd(input logic [7:0] c);
      reg_wr(REG_CMD, 32'({1'b1, c, 1'b0}));
      wait_idle();
   endtask

   task automatic mem_wr(input logic [5:0] a, input logic [3:0] d);
      reg_wr(REG_WRITE, 32'({d, a}));
      wait_idle();
      check(wire_bits[12:0], {3'h5, a, d[0], d[1], d[2], d[3]});
   endtask

   task automatic mem_rd(input logic [5:0] a, input logic [3:0] d);
      reg_wr(REG_READ, 32'(a));
      wait_idle();
      check(rv[3:0], d);
      check(wire_bits[8:0], {3'h6, a});
      check(rd_bits, {d[0], d[1], d[2], d[3]});
      i_disp_idx <= a[4:0];
      repeat (2) @(posedge i_ref_clk);
      check(o_disp_nibble, d);
   endtask

   initial begin
      #2_000_000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      sys_reset();
      check(dev_state(), 32'h00127);
      reg_rd(REG_STATUS, rv);
      check(rv, 32'h0);
      $display("test reset done");
      for (i = 0; i < 32; i++) begin
         cmd(steps[i][27:20]);
         check(wire_bits[8:1], steps[i][27:20]);
         check(dev_state(), steps[i][19:0]);
      end
      for (i = 0; i < 8; i++) begin
         cmd({5'h14, i[2:0]});
         check(o_rate_sel, i[2:0]);
      end
      reg_rd(REG_STATUS, rv);
      check(rv, 32'h20);
      $display("test commands done");
      mem_wr(6'h00, 4'h5);
      mem_wr(6'h1f, 4'ha);
      mem_wr(6'h21, 4'h1);
      mem_rd(6'h00, 4'h5);
      mem_rd(6'h1f, 4'ha);
      mem_rd(6'h01, 4'h1);
      // Second order while busy must be dropped
      reg_wr(REG_WRITE, 32'h1c2);
      reg_wr(REG_WRITE, 32'h243);
      wait_idle();
      mem_rd(6'h03, 4'h0);
      mem_rd(6'h02, 4'h7);
      reg_wr(4'h2, 32'hffffffff);
      reg_wr(REG_STATUS, 32'hffff);
      reg_rd(4'h4, rv);
      check(rv, 32'h0);
      reg_rd(REG_STATUS, rv);
      check(rv, 32'h7);
      $display("test data frames done");
      reg_wr(REG_WRITE, 32'h1c4);
      repeat (40) @(posedge i_ref_clk);
      sys_reset();
      rv = {12'h0, dev_state()};
      check(rv[15:0], 32'h0127);
      mem_rd(6'h04, 4'h0);
      mem_wr(6'h05, 4'hc);
      mem_rd(6'h05, 4'hc);
      $display("test abort by reset done");
      report_and_stop();
   end
endmodule
